// ---- logic/prr_defines.svh ----
// Constants for the packet retry recovery block.
// Assumes a 5-bit ackID space and single-word packets.
`ifndef PRR_DEFINES_SVH
`define PRR_DEFINES_SVH
`define PRR_ACKID_W     5
`define PRR_DATA_W      32
`define PRR_FIFO_DEPTH  4
`define PRR_ACKID_ONE   5'h01
`define PRR_ACKID_ZERO  5'h00
`define PRR_OUTST_MAX   5'h1f
`endif

// ---- logic/prr_pkg.sv ----
// Types shared by the packet retry recovery block.
// Assumes prr_defines.svh is on the include path.
`include "prr_defines.svh"
package prr_pkg;
    typedef enum logic [1:0] {
        IN_DISABLED, IN_WAIT, IN_STOP, IN_HALTED
    } prr_in_state_t;
    typedef enum logic [1:0] {
        OUT_DISABLED, OUT_WAIT, OUT_STOP, OUT_RECOVER
    } prr_out_state_t;
    typedef struct packed {
        logic [`PRR_ACKID_W-1:0] ackid;
        logic [`PRR_DATA_W-1:0]  data;
    } prr_pkt_t;
endpackage

// ---- logic/prr_top.sv ----
// Packet retry recovery for one serial link port: input and output
// retry machines, a receive FIFO and a replay store for resends.
// Assumes all inputs come from logic on clk_i; no pin synchronisers.
`timescale 1ns/1ps
`include "prr_defines.svh"

// ----------------------------------------------------------------
// Receive FIFO
// ----------------------------------------------------------------
module prr_fifo #(
    parameter int WIDTH = `PRR_DATA_W,
    parameter int DEPTH = `PRR_FIFO_DEPTH
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             do_wr;
    logic             do_rd;
    assign in_ready_o  = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign do_wr       = in_valid_i && in_ready_o;
    assign do_rd       = out_valid_o && out_ready_i;
    assign out_data_o  = mem[rd_ptr];
    always_ff @(posedge clk_i) begin
        if (do_wr) begin
            mem[wr_ptr] <= in_data_i;
        end
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end
endmodule

// Notes on behaviour
// - Input machine starts disabled; leaves only after init done and enable.
// - Input: disabled to waiting on enable, waiting to disabled on disable.
// - Waiting input enters stop when a packet finds the buffer full.
// - Input stop sends retry symbol with expected ackID, drops packet.
// - Input stop drops normal, raises input halted, then enters halted.
// - Input halted discards all packets silently; expected ackID frozen.
// - Restart, link-request restart or input error returns input to waiting.
// - Input error while halted is handed to the error recovery machine.
// - Output machine starts disabled; leaves only after init and enable.
// - Output waiting returns to disabled whenever output port is disabled.
// - Only an error-free retry symbol starts the output stop procedure.
// - Output stop drops normal, raises output halted, stops new packets.
// - Recovery resends the returned ackID packet and all after it.
// - Scoreboard update, restart symbol, halted clear and normal set share one edge.
// - Not-accepted or output error in recovery hands to error machine.
// - Recovery sends a restart-from-retry symbol to the partner.
// - After one recover cycle the output machine returns to waiting, where resending runs.
module prr_top (
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    input  wire logic                    init_done_i,
    input  wire logic                    in_enable_i,
    input  wire logic                    out_enable_i,
    input  wire logic                    rx_valid_i,
    input  wire prr_pkg::prr_pkt_t       rx_pkt_i,
    input  wire logic                    rx_restart_retry_i,
    input  wire logic                    rx_restart_error_i,
    input  wire logic                    rx_error_i,
    output logic                         deliver_valid_o,
    input  wire logic                    deliver_ready_i,
    output logic [`PRR_DATA_W-1:0]       deliver_data_o,
    output logic                         tx_retry_o,
    output logic [`PRR_ACKID_W-1:0]      tx_retry_ackid_o,
    output logic                         in_err_handover_o,
    input  wire logic                    send_valid_i,
    output logic                         send_ready_o,
    input  wire logic [`PRR_DATA_W-1:0]  send_data_i,
    input  wire logic                    tx_ready_i,
    output logic                         tx_pkt_valid_o,
    output prr_pkg::prr_pkt_t            tx_pkt_o,
    input  wire logic                    ack_valid_i,
    input  wire logic                    retry_sym_valid_i,
    input  wire logic                    retry_sym_ok_i,
    input  wire logic [`PRR_ACKID_W-1:0] retry_sym_ackid_i,
    input  wire logic                    not_accepted_i,
    input  wire logic                    out_error_i,
    output logic                         tx_restart_retry_o,
    output logic                         out_err_handover_o,
    output logic                         port_normal_o,
    output logic                         in_halted_o,
    output logic                         out_halted_o
);
    // ------------------------------------------------------------
    // Input side
    // ------------------------------------------------------------
    prr_pkg::prr_in_state_t   in_state;
    logic [`PRR_ACKID_W-1:0]  expected_ackid;
    logic                     fifo_ready;
    logic                     rx_take;
    logic                     rx_short;
    logic                     in_leave;
    // Only in-sequence packets count; others belong to error handling
    assign rx_take  = (in_state == prr_pkg::IN_WAIT) && rx_valid_i
                      && in_enable_i && init_done_i
                      && (rx_pkt_i.ackid == expected_ackid);
    assign rx_short = rx_take && !fifo_ready;
    assign in_leave = rx_restart_retry_i || rx_restart_error_i || rx_error_i;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            in_state <= prr_pkg::IN_DISABLED;
        end else begin
            unique case (in_state)
                prr_pkg::IN_DISABLED: begin
                    if (init_done_i && in_enable_i) begin
                        in_state <= prr_pkg::IN_WAIT;
                    end
                end
                prr_pkg::IN_WAIT: begin
                    if (!in_enable_i || !init_done_i) begin
                        in_state <= prr_pkg::IN_DISABLED;
                    end else if (rx_short) begin
                        in_state <= prr_pkg::IN_STOP;
                    end
                end
                prr_pkg::IN_STOP: begin
                    in_state <= prr_pkg::IN_HALTED;
                end
                prr_pkg::IN_HALTED: begin
                    if (in_leave) begin
                        in_state <= prr_pkg::IN_WAIT;
                    end
                end
            endcase
        end
    end
    // Expected ackID moves only on an accepted packet
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            expected_ackid <= `PRR_ACKID_ZERO;
        end else if (rx_take && fifo_ready) begin
            expected_ackid <= expected_ackid + `PRR_ACKID_ONE;
        end
    end
    // Retry symbol leaves on entry to stop, carrying the ackID we want
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_retry_o       <= 1'b0;
            tx_retry_ackid_o <= `PRR_ACKID_ZERO;
        end else begin
            tx_retry_o <= rx_short;
            if (rx_short) begin
                tx_retry_ackid_o <= expected_ackid;
            end
        end
    end
    // Error in halted state: pass the port over to error recovery
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            in_err_handover_o <= 1'b0;
        end else begin
            in_err_handover_o <= (in_state == prr_pkg::IN_HALTED)
                                 && rx_error_i;
        end
    end
    // Shortfall packet never enters the FIFO, so it is simply dropped
    prr_fifo #(
        .WIDTH (`PRR_DATA_W),
        .DEPTH (`PRR_FIFO_DEPTH)
    ) u_rx_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (rx_take),
        .in_ready_o  (fifo_ready),
        .in_data_i   (rx_pkt_i.data),
        .out_valid_o (deliver_valid_o),
        .out_ready_i (deliver_ready_i),
        .out_data_o  (deliver_data_o)
    );
    // ------------------------------------------------------------
    // Output side
    // ------------------------------------------------------------
    prr_pkg::prr_out_state_t  out_state;
    logic [`PRR_DATA_W-1:0]   replay_mem [2**`PRR_ACKID_W];
    logic [`PRR_ACKID_W-1:0]  ack_head;
    logic [`PRR_ACKID_W-1:0]  next_ackid;
    logic [`PRR_ACKID_W-1:0]  replay_ptr;
    logic [`PRR_ACKID_W-1:0]  retry_ackid;
    logic                     replaying;
    logic                     out_run;
    logic                     send_new;
    logic                     send_old;
    logic                     retry_hit;
    logic                     out_fault;
    assign retry_hit = retry_sym_valid_i && retry_sym_ok_i;
    assign out_fault = not_accepted_i || out_error_i;
    assign replaying = (replay_ptr != next_ackid);
    // Launching only while waiting keeps stop and recover quiet
    assign out_run   = (out_state == prr_pkg::OUT_WAIT) && !retry_hit
                       && tx_ready_i;
    assign send_old  = out_run && replaying;
    // One ackID kept free so a full window never looks empty
    assign send_ready_o = out_run && !replaying
                          && ((next_ackid - ack_head) != `PRR_OUTST_MAX);
    assign send_new  = send_ready_o && send_valid_i;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            out_state <= prr_pkg::OUT_DISABLED;
        end else begin
            unique case (out_state)
                prr_pkg::OUT_DISABLED: begin
                    if (init_done_i && out_enable_i) begin
                        out_state <= prr_pkg::OUT_WAIT;
                    end
                end
                prr_pkg::OUT_WAIT: begin
                    if (!out_enable_i || !init_done_i) begin
                        out_state <= prr_pkg::OUT_DISABLED;
                    end else if (retry_hit) begin
                        out_state <= prr_pkg::OUT_STOP;
                    end
                end
                prr_pkg::OUT_STOP: begin
                    // Single-word packets: nothing is in flight to finish
                    out_state <= prr_pkg::OUT_RECOVER;
                end
                prr_pkg::OUT_RECOVER: begin
                    out_state <= prr_pkg::OUT_WAIT;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            retry_ackid <= `PRR_ACKID_ZERO;
        end else if (out_state == prr_pkg::OUT_WAIT && retry_hit) begin
            retry_ackid <= retry_sym_ackid_i;
        end
    end

    // Scoreboard: packets before the returned ackID count as accepted
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_head   <= `PRR_ACKID_ZERO;
            next_ackid <= `PRR_ACKID_ZERO;
            replay_ptr <= `PRR_ACKID_ZERO;
        end else begin
            if (out_state == prr_pkg::OUT_RECOVER && !out_fault) begin
                ack_head   <= retry_ackid;
                replay_ptr <= retry_ackid;
            end else begin
                if (ack_valid_i && ack_head != replay_ptr) begin
                    ack_head <= ack_head + `PRR_ACKID_ONE;
                end
                if (send_old) begin
                    replay_ptr <= replay_ptr + `PRR_ACKID_ONE;
                end else if (send_new) begin
                    replay_ptr <= replay_ptr + `PRR_ACKID_ONE;
                end
            end
            if (send_new) begin
                next_ackid <= next_ackid + `PRR_ACKID_ONE;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (send_new) begin
            replay_mem[next_ackid] <= send_data_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_pkt_valid_o <= 1'b0;
            tx_pkt_o       <= '0;
        end else begin
            tx_pkt_valid_o <= send_old || send_new;
            if (send_old) begin
                tx_pkt_o.ackid <= replay_ptr;
                tx_pkt_o.data  <= replay_mem[replay_ptr];
            end else if (send_new) begin
                tx_pkt_o.ackid <= next_ackid;
                tx_pkt_o.data  <= send_data_i;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_restart_retry_o <= 1'b0;
            out_err_handover_o <= 1'b0;
        end else begin
            tx_restart_retry_o <= (out_state == prr_pkg::OUT_RECOVER)
                                  && !out_fault;
            out_err_handover_o <= (out_state == prr_pkg::OUT_RECOVER)
                                  && out_fault;
        end
    end

    // ------------------------------------------------------------
    // Status
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            in_halted_o  <= 1'b0;
            out_halted_o <= 1'b0;
        end else begin
            in_halted_o  <= rx_short || in_state == prr_pkg::IN_STOP
                            || (in_state == prr_pkg::IN_HALTED
                                && !in_leave);
            // A retry met by a closing port must not flag a halt
            out_halted_o <= (out_state == prr_pkg::OUT_WAIT && retry_hit
                             && out_enable_i && init_done_i)
                            || out_state == prr_pkg::OUT_STOP;
        end
    end

    assign port_normal_o = !in_halted_o && !out_halted_o;
endmodule

// ---- tb/prr_top_chk.sv ----
// Port relation checks for prr_top, bound in at the foot.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ps
`include "prr_defines.svh"
module prr_top_chk (
    input wire logic                    clk_i,
    input wire logic                    rst_i,
    input wire logic                    init_done_i,
    input wire logic                    in_enable_i,
    input wire logic                    out_enable_i,
    input wire logic                    rx_valid_i,
    input wire prr_pkg::prr_pkt_t       rx_pkt_i,
    input wire logic                    rx_restart_retry_i,
    input wire logic                    rx_restart_error_i,
    input wire logic                    rx_error_i,
    input wire logic                    tx_retry_o,
    input wire logic [`PRR_ACKID_W-1:0] tx_retry_ackid_o,
    input wire logic                    in_err_handover_o,
    input wire logic                    tx_pkt_valid_o,
    input wire prr_pkg::prr_pkt_t       tx_pkt_o,
    input wire logic                    retry_sym_valid_i,
    input wire logic                    retry_sym_ok_i,
    input wire logic [`PRR_ACKID_W-1:0] retry_sym_ackid_i,
    input wire logic                    tx_restart_retry_o,
    input wire logic                    out_err_handover_o,
    input wire logic                    port_normal_o,
    input wire logic                    in_halted_o,
    input wire logic                    out_halted_o
);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_normal_flag: assert property (
        port_normal_o == !(in_halted_o || out_halted_o))
        else $error("normal flag wrong");
    chk_retry_entry: assert property (
        tx_retry_o |-> $past(rx_valid_i) && in_halted_o && !port_normal_o
            && tx_retry_ackid_o == $past(rx_pkt_i.ackid))
        else $error("retry symbol wrong");
    chk_in_enabled: assert property (
        tx_retry_o |-> $past(init_done_i && in_enable_i))
        else $error("retry while input disabled");
    chk_in_exit: assert property (
        in_halted_o && $past(in_halted_o) && (rx_restart_retry_i
            || rx_restart_error_i || rx_error_i) |=> !in_halted_o)
        else $error("input halt not left");
    chk_in_handover: assert property (
        in_halted_o && $past(in_halted_o) && rx_error_i
            |=> in_err_handover_o)
        else $error("input handover missing");
    chk_sym_ok: assert property (
        $rose(out_halted_o) |-> $past(retry_sym_valid_i && retry_sym_ok_i))
        else $error("output halt without good symbol");
    chk_out_quiet: assert property (
        out_halted_o |-> !tx_pkt_valid_o)
        else $error("packet sent while halted");
    chk_out_restart: assert property (
        $rose(out_halted_o) |-> out_halted_o[*2] ##1 (!out_halted_o
            && (tx_restart_retry_o != out_err_handover_o)))
        else $error("recovery end wrong");
    chk_resend_head: assert property (
        tx_restart_retry_o ##1 tx_pkt_valid_o
            |-> tx_pkt_o.ackid == $past(retry_sym_ackid_i, 4))
        else $error("resend head wrong");
    chk_out_enabled: assert property (
        $rose(out_halted_o) |-> $past(init_done_i && out_enable_i))
        else $error("halt while output disabled");
    cover property (tx_retry_o);
    cover property (tx_restart_retry_o);
    cover property (out_err_handover_o);
    cover property (in_err_handover_o);
endmodule
bind prr_top prr_top_chk u_chk (.*);

// ---- tb/prr_link_partner.sv ----
// Attached port model: records packets, acks on request, stalls
// when slow, and records the ackID of each retry symbol. Shares clk_i.
`timescale 1ns/1ps
`include "prr_defines.svh"
module prr_link_partner (
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    input  wire logic                    slow_i,
    input  wire logic                    ack_on_i,
    input  wire logic                    pkt_valid_i,
    input  wire prr_pkg::prr_pkt_t       pkt_i,
    input  wire logic                    retry_i,
    input  wire logic [`PRR_ACKID_W-1:0] retry_ackid_i,
    output logic                         ready_o,
    output logic                         ack_o,
    output logic      [`PRR_ACKID_W-1:0] resend_ackid_o
);
    prr_pkg::prr_pkt_t seen[$];
    logic              phase;
    // Stalling every other cycle makes the sender hold its request
    assign ready_o = !slow_i || phase;
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            phase          <= 1'b0;
            ack_o          <= 1'b0;
            resend_ackid_o <= 5'h00;
        end else begin
            phase <= !phase;
            ack_o <= ack_on_i && pkt_valid_i;
            if (pkt_valid_i)
                seen.push_back(pkt_i);
            if (retry_i)
                resend_ackid_o <= retry_ackid_i;
        end
    end
endmodule

// ---- tb/tb_prr_top.sv ----
// Bench for prr_top; inputs change on falling edges.
// Assumes the checker binds itself to prr_top.
`timescale 1ns/1ps
`include "prr_defines.svh"
module tb_prr_top;
    logic clk_i, rst_i, init_done_i, in_enable_i, out_enable_i, rx_valid_i;
    logic rx_restart_retry_i, rx_restart_error_i, rx_error_i, ack_on, slow;
    logic deliver_ready_i, send_valid_i, retry_sym_valid_i, retry_sym_ok_i;
    logic not_accepted_i, out_error_i, tx_ready_i, ack_valid_i, tx_retry_o;
    logic deliver_valid_o, in_err_handover_o, send_ready_o, tx_pkt_valid_o;
    logic tx_restart_retry_o, out_err_handover_o, port_normal_o;
    logic in_halted_o, out_halted_o;
    logic [31:0] send_data_i, deliver_data_o;
    logic [4:0]  retry_sym_ackid_i, tx_retry_ackid_o, resend, exp_id;
    prr_pkg::prr_pkt_t rx_pkt_i, tx_pkt_o;
    int num_errors, checked, cyc;
    prr_top DUT (.*);
    prr_link_partner u_far (.clk_i, .rst_i, .slow_i(slow), .ack_on_i(ack_on),
        .pkt_valid_i(tx_pkt_valid_o), .pkt_i(tx_pkt_o), .retry_i(tx_retry_o),
        .retry_ackid_i(tx_retry_ackid_o), .ready_o(tx_ready_i),
        .ack_o(ack_valid_i), .resend_ackid_o(resend));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = !clk_i;
    end
    // Whole run is under two hundred cycles; the ceiling leaves wide margin
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            results();
        end
    end
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(string what, logic [36:0] exp, logic [36:0] got);
        checked++;
        if (got !== exp) begin
            $display("BAD %s exp %h got %h", what, exp, got);
            num_errors++;
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic tick(int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic rx(input logic [4:0] id, output logic rt);
        rx_pkt_i = {id, 27'h0, id};
        rx_valid_i = 1'b1;
        tick(1);
        rt = tx_retry_o;
        rx_valid_i = 1'b0;
        tick(1);
    endtask
    task automatic drain(logic [4:0] id);
        chk("deliver_valid", 1, deliver_valid_o);
        chk("deliver_data", {27'h0, id}, deliver_data_o);
        deliver_ready_i = 1'b1;
        tick(1);
        deliver_ready_i = 1'b0;
        tick(1);
    endtask
    task automatic send(logic [31:0] d);
        send_valid_i = 1'b1;
        send_data_i = d;
        do @(posedge clk_i); while (send_ready_o !== 1'b1);
        @(negedge clk_i);
        send_valid_i = 1'b0;
        tick(1);
    endtask
    task automatic sym(logic ok, logic [4:0] id, int fault);
        logic en;
        en = ok & out_enable_i & init_done_i;
        retry_sym_valid_i = 1'b1;
        retry_sym_ok_i = ok;
        retry_sym_ackid_i = id;
        tick(1);
        retry_sym_valid_i = 1'b0;
        chk("out_halted", en, out_halted_o);
        chk("normal", !en, port_normal_o);
        tick(1);
        not_accepted_i = (fault == 1);
        out_error_i = (fault == 2);
        tick(1);
        not_accepted_i = 1'b0;
        out_error_i = 1'b0;
        chk("restart", en && fault == 0, tx_restart_retry_o);
        chk("out_handover", en && fault != 0, out_err_handover_o);
        chk("halt_clear", 0, out_halted_o);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic sc_reset();
        logic r;
        chk("reset_flags", 3'b100, {port_normal_o, in_halted_o,
            out_halted_o});
        in_enable_i = 1'b1;
        out_enable_i = 1'b1;
        tick(2);
        rx(5'h00, r);
        chk("rx_no_init", 0, deliver_valid_o);
        sym(1, 5'h00, 0);
        init_done_i = 1'b1;
        tick(2);
    endtask
    task automatic sc_in(int cause);
        logic r;
        for (int i = 0; i < 4; i++)
            rx(exp_id + 5'(i), r);
        rx(exp_id + 5'h04, r);
        chk("retry_sent", 1, r);
        chk("retry_ackid", exp_id + 5'h04, tx_retry_ackid_o);
        chk("in_halted", 2'b10, {in_halted_o, port_normal_o});
        chk("resend_from", exp_id + 5'h04, resend);
        for (int i = 0; i < 4; i++)
            drain(exp_id + 5'(i));
        exp_id = exp_id + 5'h04;
        rx(exp_id, r);
        chk("halt_drop", 0, deliver_valid_o);
        rx_restart_retry_i = (cause == 0);
        rx_restart_error_i = (cause == 1);
        rx_error_i = (cause == 2);
        tick(1);
        {rx_restart_retry_i, rx_restart_error_i, rx_error_i} = 3'h0;
        chk("in_handover", cause == 2, in_err_handover_o);
        chk("in_resume", 2'b01, {in_halted_o, port_normal_o});
        rx(exp_id, r);
        drain(exp_id);
        exp_id = exp_id + 5'h01;
    endtask
    task automatic sc_out();
        int j;
        slow = 1'b1;
        for (int i = 0; i < 3; i++)
            send(32'h0000_a000 + 32'(i));
        sym(0, 5'h01, 0);
        sym(1, 5'h01, 0);
        for (int n = 0; n < 20 && u_far.seen.size() < 5; n++)
            tick(1);
        for (int i = 0; i < 5; i++) begin
            j = (i < 3) ? i : i - 2;
            chk("far_ackid", 5'(j), u_far.seen[i].ackid);
            chk("far_data", 32'ha000 + 32'(j), u_far.seen[i].data);
        end
        send(32'h0000_a003);
        chk("new_ackid", 5'h03, u_far.seen[5].ackid);
        for (int k = 1; k < 3; k++)
            sym(1, 5'h02, k);
        ack_on = 1'b1;
        send(32'h0000_a004);
        chk("far_count", 7, u_far.seen.size());
        chk("after_fault", 5'h04, u_far.seen[6].ackid);
    endtask
    task automatic sc_dis();
        logic r;
        out_enable_i = 1'b0;
        in_enable_i = 1'b0;
        tick(2);
        sym(1, 5'h03, 0);
        rx(exp_id, r);
        chk("rx_disabled", 0, deliver_valid_o);
    endtask
    initial begin
        rst_i = 1'b1;
        {init_done_i, in_enable_i, out_enable_i, rx_valid_i, slow, ack_on,
            rx_restart_retry_i, rx_restart_error_i, rx_error_i, out_error_i,
            deliver_ready_i, send_valid_i, retry_sym_valid_i, retry_sym_ok_i,
            not_accepted_i, rx_pkt_i, send_data_i, retry_sym_ackid_i,
            exp_id} = '0;
        tick(6);
        rst_i = 1'b0;
        tick(1);
        sc_reset();
        for (int c = 0; c < 3; c++)
            sc_in(c);
        sc_out();
        sc_dis();
        results();
    end
endmodule
